//--- core/pbv_map.svh
// address map, header layout and fixed values of the patch block validator
`ifndef PBV_MAP_SVH
`define PBV_MAP_SVH

`define PBV_ADDR_PLAT     32'h0000_0017
`define PBV_ADDR_TRIG     32'h0000_0079
`define PBV_ADDR_SIG      32'h0000_008b
`define PBV_HDR_VER_1     32'h0000_0001
`define PBV_BLK_DWORDS    512
`define PBV_HDR_DWORDS    12
`define PBV_DW_BYTES      32'h0000_0004
`define PBV_IDX_VER       9'h000
`define PBV_IDX_REV       9'h001
`define PBV_IDX_PROC      9'h003
`define PBV_IDX_FLAGS     9'h006
`define PBV_PLAT_LSB      50
`define PBV_SIG_LSB       32
`define PBV_RESERVED_HI   11'h000
`define PBV_RESERVED_LO   50'h0

`endif

//--- core/pbv_pkg.sv
// types shared by the patch block validator
package pbv_pkg;

   typedef enum logic [1:0]
   {
      PBV_IDLE,
      PBV_FETCH,
      PBV_JUDGE
   } pbv_state_t;

   // model register access request
   typedef struct packed
   {
      logic        rd;
      logic        wr;
      logic [31:0] addr;
      logic [63:0] wdata;
   } pbv_mreq_t;

   // header fields caught while the block streams in
   typedef struct packed
   {
      logic [31:0] version;
      logic [31:0] revision;
      logic [31:0] processor;
      logic [31:0] flags;
   } pbv_hdr_t;

endpackage

//--- core/pbv_validator.sv
// patch block validator with platform id, trigger and signature registers
//
// Overview of operation
// [RULE1] block is 2048 bytes: 48-byte header then 2000 payload bytes
// [RULE2] dword 0 is header version; only version 1 is accepted
// [RULE3] dword at offset 4 is revision, reported as signature after load
// [RULE4] offset 8 holds creation date mmddyyyy, ignored by hardware
// [RULE5] offset 12 holds processor signature, same encoding as query result
// [RULE6] refuse a block whose processor signature differs from installed one
// [RULE7] all 512 dwords including checksum must sum to zero
// [RULE8] offset 20 names loader sequence version, loader's concern
// [RULE9] low 8 bits at offset 24 flag valid platform types
// [RULE10] 20 bytes at offset 28 reserved, carry no meaning
// [RULE11] software interprets header layout by its version value
// [RULE12] platform type id is 64-bit read-only register at 017h
// [RULE13] platform bits 52:50 index the flag bit that must be set
// [RULE14] payload is data only; its encoding rejects tampered blocks
// [RULE15] write to 79h starts loading block at supplied linear address
// [RULE16] hard reset discards patch; reloading same patch is harmless
// [RULE17] signature query puts active revision in 08bh, unchanged if none
// [RULE18] platform id bits 63:53 and 49:0 read as zero
// [RULE19] any failed check raises load failed and keeps old revision
`timescale 1ns/1ps
`default_nettype none
`include "pbv_map.svh"

module pbv_validator
#(
   parameter int BLK_DWORDS = `PBV_BLK_DWORDS
)
(
   // clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   // installed processor identity, sampled after reset
   input  wire logic [31:0]       cpu_signature_i,
   input  wire logic [2:0]        platform_bits_i,
   // model register port
   input  wire pbv_pkg::pbv_mreq_t mreq_i,
   output var  logic [63:0]       mr_rdata_o,
   output var  logic              mr_ack_o,
   // signature query
   input  wire logic              sig_query_i,
   // block memory fetch
   output var  logic              mem_req_o,
   output var  logic [31:0]       mem_addr_o,
   input  wire logic              mem_valid_i,
   input  wire logic [31:0]       mem_rdata_i,
   // load status
   output var  logic              busy_o,
   output var  logic              load_ok_o,
   output var  logic              load_fail_o
);
   import pbv_pkg::*;

   localparam int CNT_W = $clog2(BLK_DWORDS);

   // the header index is nine bits wide, so larger blocks would alias it
   if (BLK_DWORDS < `PBV_HDR_DWORDS || BLK_DWORDS > `PBV_BLK_DWORDS
       || (BLK_DWORDS & (BLK_DWORDS - 1)) != 0)
   begin
      $error("BLK_DWORDS must be a power of two from header size to 512");
   end

   // platform flag hit for the installed platform index
   function automatic logic flag_hit(input logic [31:0] flags,
                                     input logic [2:0]  idx);
      flag_hit = flags[idx];
   endfunction

   // state
   pbv_state_t        state_ff;
   pbv_state_t        nxt_state;
   logic [CNT_W-1:0]  cnt_ff;
   logic [CNT_W-1:0]  nxt_cnt;
   logic [31:0]       sum_ff;
   logic [31:0]       nxt_sum;
   pbv_hdr_t          hdr_ff;
   pbv_hdr_t          nxt_hdr;
   logic [31:0]       addr_ff;
   logic [31:0]       nxt_addr;
   logic              req_ff;
   logic              nxt_req;
   logic              ok_ff;
   logic              nxt_ok;
   logic              fail_ff;
   logic              nxt_fail;
   logic              present_ff;
   logic              nxt_present;
   logic [31:0]       rev_ff;
   logic [31:0]       nxt_rev;
   logic [63:0]       sig_ff;
   logic [63:0]       nxt_sig;
   logic [63:0]       rdata_ff;
   logic [63:0]       nxt_rdata;
   logic              ack_ff;
   logic              nxt_ack;
   logic [2:0]        plat_ff;
   logic [2:0]        nxt_plat;
   logic [31:0]       cpu_sig_ff;
   logic [31:0]       nxt_cpu_sig;
   logic              strap_ff;
   logic              nxt_strap;
   logic              busy_ff;
   logic              nxt_busy;
   logic              pass;

   // a dword taken with the last index closes the block
   logic              take;
   logic [31:0]       sum_now;
   logic [8:0]        idx9;

   always_comb
   begin
      take    = (state_ff == PBV_FETCH) && mem_valid_i;
      sum_now = sum_ff + mem_rdata_i;                            // [RULE7]
      idx9    = 9'(cnt_ff);
      // date, loader version and reserved dwords are summed, never judged
      pass = (hdr_ff.version == `PBV_HDR_VER_1)                  // [RULE2]
           && (hdr_ff.processor == cpu_sig_ff)            // [RULE5] [RULE6]
           && flag_hit(hdr_ff.flags, plat_ff)            // [RULE9] [RULE13]
           && (sum_ff == 32'h0);                        // [RULE7] [RULE14]
   end

   // loader engine
   always_comb
   begin
      nxt_state   = state_ff;
      nxt_cnt     = cnt_ff;
      nxt_sum     = sum_ff;
      nxt_hdr     = hdr_ff;
      nxt_addr    = addr_ff;
      nxt_req     = req_ff;
      nxt_ok      = ok_ff;
      nxt_fail    = fail_ff;
      nxt_present = present_ff;
      nxt_rev     = rev_ff;
      unique case (state_ff)
         PBV_IDLE:
         begin
            // a trigger during a load is dropped, not queued
            if (mreq_i.wr && mreq_i.addr == `PBV_ADDR_TRIG)      // [RULE15]
            begin
               nxt_state = PBV_FETCH;
               nxt_addr  = mreq_i.wdata[31:0];
               nxt_req   = 1'b1;
               nxt_cnt   = '0;
               nxt_sum   = 32'h0;
               nxt_hdr   = '0;
               nxt_ok    = 1'b0;
               nxt_fail  = 1'b0;
            end
         end
         PBV_FETCH:
         begin
            if (take)
            begin
               nxt_sum  = sum_now;
               nxt_addr = addr_ff + `PBV_DW_BYTES;
               nxt_cnt  = cnt_ff + 1'b1;
               // payload words only feed the sum; nothing is executed
               if (idx9 == `PBV_IDX_VER)                         // [RULE14]
               begin
                  nxt_hdr.version = mem_rdata_i;
               end
               if (idx9 == `PBV_IDX_REV)
               begin
                  nxt_hdr.revision = mem_rdata_i;
               end
               if (idx9 == `PBV_IDX_PROC)
               begin
                  nxt_hdr.processor = mem_rdata_i;
               end
               if (idx9 == `PBV_IDX_FLAGS)
               begin
                  nxt_hdr.flags = mem_rdata_i;
               end
               if (cnt_ff == CNT_W'(BLK_DWORDS - 1))             // [RULE1]
               begin
                  nxt_req   = 1'b0;
                  nxt_state = PBV_JUDGE;
               end
            end
         end
         PBV_JUDGE:
         begin
            nxt_state = PBV_IDLE;
            if (pass)
            begin
               // same revision again just rewrites the same value
               nxt_ok      = 1'b1;                               // [RULE16]
               nxt_present = 1'b1;
               nxt_rev     = hdr_ff.revision;                    // [RULE3]
            end
            else
            begin
               nxt_fail = 1'b1;                                  // [RULE19]
            end
         end
      endcase
      nxt_busy = (nxt_state != PBV_IDLE);
   end

   // model registers
   always_comb
   begin
      nxt_sig     = sig_ff;
      nxt_rdata   = 64'h0;
      nxt_ack     = mreq_i.rd || mreq_i.wr;
      nxt_plat    = plat_ff;
      nxt_cpu_sig = cpu_sig_ff;
      nxt_strap   = 1'b1;
      if (!strap_ff)
      begin
         nxt_plat    = platform_bits_i;
         nxt_cpu_sig = cpu_signature_i;
      end
      if (mreq_i.wr && mreq_i.addr == `PBV_ADDR_SIG)
      begin
         nxt_sig = mreq_i.wdata;
      end
      // with a patch present, query wins over a same-cycle software preload
      if (sig_query_i && present_ff)                             // [RULE17]
      begin
         nxt_sig = {rev_ff, 32'h0};
      end
      if (mreq_i.rd)
      begin
         unique case (mreq_i.addr)
            `PBV_ADDR_PLAT:                                      // [RULE12]
               nxt_rdata = {`PBV_RESERVED_HI, plat_ff,
                            `PBV_RESERVED_LO};                   // [RULE18]
            `PBV_ADDR_SIG:
               nxt_rdata = sig_ff;
            default:
               nxt_rdata = 64'h0;
         endcase
      end
   end

   // hard reset clears the patch; no soft init input reaches it
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         state_ff   <= PBV_IDLE;
         cnt_ff     <= '0;
         sum_ff     <= 32'h0;
         hdr_ff     <= '0;
         addr_ff    <= 32'h0;
         req_ff     <= 1'b0;
         ok_ff      <= 1'b0;
         fail_ff    <= 1'b0;
         present_ff <= 1'b0;                                     // [RULE16]
         rev_ff     <= 32'h0;
         sig_ff     <= 64'h0;
         rdata_ff   <= 64'h0;
         ack_ff     <= 1'b0;
         plat_ff    <= 3'h0;
         cpu_sig_ff <= 32'h0;
         strap_ff   <= 1'b0;
         busy_ff    <= 1'b0;
      end
      else
      begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         sum_ff     <= nxt_sum;
         hdr_ff     <= nxt_hdr;
         addr_ff    <= nxt_addr;
         req_ff     <= nxt_req;
         ok_ff      <= nxt_ok;
         fail_ff    <= nxt_fail;
         present_ff <= nxt_present;
         rev_ff     <= nxt_rev;
         sig_ff     <= nxt_sig;
         rdata_ff   <= nxt_rdata;
         ack_ff     <= nxt_ack;
         plat_ff    <= nxt_plat;
         cpu_sig_ff <= nxt_cpu_sig;
         strap_ff   <= nxt_strap;
         busy_ff    <= nxt_busy;
      end
   end

   assign mr_rdata_o  = rdata_ff;
   assign mr_ack_o    = ack_ff;
   assign mem_req_o   = req_ff;
   assign mem_addr_o  = addr_ff;
   assign busy_o      = busy_ff;
   assign load_ok_o   = ok_ff;
   assign load_fail_o = fail_ff;

endmodule
`default_nettype wire

//--- tb/pbv_mem_model.sv
// block memory answering the fetch port, promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module pbv_mem_model
#(
   parameter logic [31:0] BASE = 32'h0000_0100
)
(
   input  wire logic        clk_sys_i,
   input  wire logic        req_i,
   input  wire logic [31:0] addr_i,
   input  wire logic        slow_i,
   output var  logic        valid_o,
   output var  logic [31:0] rdata_o
);
   logic [31:0] blk [16];
   logic        ph_ff = 1'b0;
   logic [31:0] last_ff = 32'h0;
   logic [31:0] idx;
   always_ff @(posedge clk_sys_i)
   begin
      ph_ff <= !ph_ff;
      if (valid_o)
         last_ff <= rdata_o;
   end
   // idle data is the inverse of the last word so stale data never matches
   always_comb
   begin
      idx = (addr_i - BASE) >> 2;
      valid_o = req_i && !(slow_i && ph_ff);
      rdata_o = valid_o ? blk[idx[3:0]] : ~last_ff;
   end
endmodule
`default_nettype wire

//--- tb/pbv_props.sv
// port assertions of the patch block validator
`timescale 1ns/1ps
`default_nettype none
module pbv_props
(
   // clock, reset, strap
   input wire logic              clk_sys_i,
   input wire logic              rst_i,
   input wire logic [2:0]        platform_bits_i,
   // register port
   input wire pbv_pkg::pbv_mreq_t mreq_i,
   input wire logic [63:0]       mr_rdata_o,
   input wire logic              mr_ack_o,
   // fetch and status
   input wire logic              mem_req_o,
   input wire logic [31:0]       mem_addr_o,
   input wire logic              mem_valid_i,
   input wire logic              busy_o,
   input wire logic              load_ok_o,
   input wire logic              load_fail_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   sequence s_trig;
      mreq_i.wr && mreq_i.addr == 32'h79 && !busy_o;
   endsequence
   sequence s_take;
      mem_req_o && mem_valid_i ##1 mem_req_o;
   endsequence
   property p_ack;
      mreq_i.rd || mreq_i.wr |=> mr_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_plat;
      mreq_i.rd && mreq_i.addr == 32'h17 |=>
         mr_rdata_o == {11'h0, platform_bits_i, 50'h0};
   endproperty
   a_plat: assert property (p_plat) else $error("plat id");
   property p_resv;
      mr_ack_o && $past(mreq_i.addr) == 32'h17 |->
         mr_rdata_o[63:53] == 11'h0 && mr_rdata_o[49:0] == 50'h0;
   endproperty
   a_resv: assert property (p_resv) else $error("resv bits");
   property p_trig;
      s_trig |=> busy_o && mem_req_o && !load_ok_o && !load_fail_o
         && mem_addr_o == $past(mreq_i.wdata[31:0]);
   endproperty
   a_trig: assert property (p_trig) else $error("trigger");
   property p_step;
      s_take |-> mem_addr_o == $past(mem_addr_o) + 32'h4;
   endproperty
   a_step: assert property (p_step) else $error("addr step");
   property p_hold;
      mem_req_o && !mem_valid_i |=> $stable(mem_addr_o) && mem_req_o;
   endproperty
   a_hold: assert property (p_hold) else $error("addr hold");
   property p_judge;
      $fell(mem_req_o) |=> !busy_o && (load_ok_o ^ load_fail_o);
   endproperty
   a_judge: assert property (p_judge) else $error("judge");
   property p_idle;
      !mr_ack_o |-> mr_rdata_o == 64'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("rdata idle");
endmodule
`default_nettype wire

//--- tb/pbv_validator_tb.sv
// self-checking bench of the patch block validator
`timescale 1ns/1ps
`default_nettype none
`include "pbv_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   err_count++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module pbv_validator_tb;
   import pbv_pkg::*;
   localparam logic [31:0] SIG = 32'h0000_0a5c; // arbitrary value
   localparam logic [2:0]  PLAT = 3'h5;
   logic clk_sys_i, rst_i, sig_q, slow, ack, mreq, mv, busy, ok, fail;
   logic [63:0] rd, rdat;
   logic [31:0] maddr, mdat, rev;
   logic [2:0]  plat;
   pbv_mreq_t   mr;
   int          err_count, n_checks;
   pbv_validator #(.BLK_DWORDS(16)) dut (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .cpu_signature_i(SIG), .platform_bits_i(plat),
      .mreq_i(mr), .mr_rdata_o(rd), .mr_ack_o(ack), .sig_query_i(sig_q),
      .mem_req_o(mreq), .mem_addr_o(maddr), .mem_valid_i(mv),
      .mem_rdata_i(mdat), .busy_o(busy), .load_ok_o(ok),
      .load_fail_o(fail));
   pbv_mem_model mem (.clk_sys_i(clk_sys_i), .req_i(mreq),
      .addr_i(maddr), .slow_i(slow), .valid_o(mv), .rdata_o(mdat));
   initial
   begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = !clk_sys_i;
   end
   task automatic results();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic req(input logic r, input logic [31:0] a);
      mr = '{rd: r, wr: !r, addr: a, wdata: {32'h0, 32'h0000_0100}};
      @(posedge clk_sys_i) #1;
      mr = '0;
      rdat = rd;
      `CHK("ack", 1'b1, ack)
      // let an edge pass so back-to-back calls never rewrite mr at once
      @(posedge clk_sys_i) #1;
      `CHK("ack end", 1'b0, ack)
   endtask
   task automatic query();
      sig_q = 1'b1;
      @(posedge clk_sys_i) #1;
      sig_q = 1'b0;
      req(1'b1, `PBV_ADDR_SIG);
   endtask
   task automatic load(input logic [31:0] v, p, f, c, input logic e);
      logic [31:0] s;
      s = 32'h0;
      for (int i = 0; i < 16; i++)
         mem.blk[i] = (i < 12) ? 32'h0 : 32'h1000 + i;
      mem.blk[0] = v;
      mem.blk[1] = rev;
      mem.blk[2] = 32'h0304_2024;
      mem.blk[3] = p;
      mem.blk[5] = 32'h1;
      mem.blk[6] = f;
      for (int i = 0; i < 16; i++)
         s += mem.blk[i];
      mem.blk[4] = c - s;
      req(1'b0, `PBV_ADDR_TRIG);
      `CHK("busy", 1'b1, busy)
      for (int i = 0; i < 200 && busy; i++)
         @(posedge clk_sys_i) #1;
      if (busy)
      begin
         err_count++;
         results();
      end
      `CHK("ok", e, ok)
      `CHK("fail", !e, fail)
   endtask
   task automatic t_regs();
      req(1'b1, `PBV_ADDR_PLAT);
      `CHK("plat", {11'h0, PLAT, 50'h0}, rdat)
      req(1'b0, `PBV_ADDR_PLAT);
      req(1'b1, `PBV_ADDR_PLAT);
      `CHK("plat ro", {11'h0, PLAT, 50'h0}, rdat)
      req(1'b1, 32'h0000_0044);
      `CHK("unmapped", 64'h0, rdat)
      $display("t_regs done");
   endtask
   task automatic t_good();
      rev = 32'h0000_0012;
      slow = 1'b1;
      load(`PBV_HDR_VER_1, SIG, 32'h1 << PLAT, 32'h0, 1'b1);
      slow = 1'b0;
      query();
      `CHK("sig", {rev, 32'h0}, rdat)
      $display("t_good done");
   endtask
   task automatic t_bad();
      rev = 32'h0000_0099;
      load(32'h2, SIG, 32'h1 << PLAT, 32'h0, 1'b0);
      load(1, SIG ^ 32'h1, 32'h1 << PLAT, 32'h0, 1'b0);
      load(1, SIG, ~(32'h1 << PLAT), 32'h0, 1'b0);
      load(1, SIG, 32'h1 << PLAT, 32'h1, 1'b0);
      query();
      `CHK("sig kept", {32'h12, 32'h0}, rdat)
      $display("t_bad done");
   endtask
   task automatic t_reset();
      rst_i = 1'b1;
      plat = 3'h2;
      repeat (5) @(posedge clk_sys_i) #1;
      rst_i = 1'b0;
      repeat (2) @(posedge clk_sys_i) #1;
      query();
      `CHK("sig reset", 64'h0, rdat)
      req(1'b0, `PBV_ADDR_SIG);
      query();
      `CHK("sig none", 64'h100, rdat)
      req(1'b1, `PBV_ADDR_PLAT);
      `CHK("plat new", {11'h0, 3'h2, 50'h0}, rdat)
      rev = 32'h0000_0034;
      load(1, SIG, 32'h1 << PLAT, 32'h0, 1'b0);
      repeat (2) load(1, SIG, 32'h1 << plat, 32'h0, 1'b1);
      query();
      `CHK("sig reload", {rev, 32'h0}, rdat)
      $display("t_reset done");
   endtask
   initial
   begin
      rst_i = 1'b1;
      sig_q = 1'b0;
      slow = 1'b0;
      plat = PLAT;
      mr = '0;
      err_count = 0;
      n_checks = 0;
      repeat (5) @(posedge clk_sys_i) #1;
      rst_i = 1'b0;
      repeat (2) @(posedge clk_sys_i) #1;
      t_regs();
      t_good();
      t_bad();
      t_reset();
      results();
   end
endmodule
bind pbv_validator pbv_props u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .platform_bits_i(platform_bits_i), .mreq_i(mreq_i),
   .mr_rdata_o(mr_rdata_o), .mr_ack_o(mr_ack_o), .mem_req_o(mem_req_o),
   .mem_addr_o(mem_addr_o), .mem_valid_i(mem_valid_i), .busy_o(busy_o),
   .load_ok_o(load_ok_o), .load_fail_o(load_fail_o));
`default_nettype wire
